// File: include/ofec_map.svh
// offsets, field positions, reset values and timing counts of the
// octal flash error-check block; included by the package, ofec_inband_rst and ofec_top.
`ifndef OFEC_MAP_SVH
`define OFEC_MAP_SVH
`define OFEC_CFG_ADDR 8'h0b
`define OFEC_STAT_ADDR 8'h0c
`define OFEC_FA0_ADDR 8'h0d
`define OFEC_FA1_ADDR 8'h0e
`define OFEC_FA2_ADDR 8'h0f
`define OFEC_FA3_ADDR 8'h10
`define OFEC_CFG_EVSEL 2
`define OFEC_CFG_PCHK 3
`define OFEC_CFG_CSZ 5:4
`define OFEC_CFG_RCHK 7
`define OFEC_CFG_RST 8'h40
`define OFEC_BASE_CHUNK 8'h10
`define OFEC_IBR_PAT 4'h5
`define OFEC_ERROR_ASSERT_LATENCY_CLK 2
`define OFEC_CLK_NS 10
`define OFEC_IBR_NS 200
`define OFEC_IBR_CYC ((`OFEC_IBR_NS) / (`OFEC_CLK_NS))
`endif

// File: include/ofec_pkg.sv
// types and shared functions of the octal flash error-check block
// assumes ofec_map.svh on the include path
`include "ofec_map.svh"
package ofec_pkg;
  typedef enum {OFEC_IDLE, OFEC_PROG, OFEC_READ, OFEC_HALT} ofec_mode_t;

  typedef struct packed {
    logic [7:0] code;
    logic [7:0] cnt;
  } ofec_acc_st_t;

  typedef struct packed {
    logic [2:0] cnt;
    logic [3:0] pat;
    logic [7:0] hold;
    logic fire;
    logic busy;
  } ofec_ibr_st_t;

  typedef struct packed {
    logic [10:0] sy1;
    logic [10:0] sy2;
    logic [1:0] sy3;
    logic [7:0] cfg;
    logic crc_err;
    logic par_err;
    logic ecc_dbl;
    logic [3:0] ecc_cnt;
    logic pab;
    logic [31:0] faddr;
    logic faddr_vld;
    logic prog_fail;
    logic err_o;
    logic err_oe;
    ofec_mode_t mode;
    logic chk;
    logic seen_clk;
    logic [7:0] dq_o;
    logic dq_oe;
    logic take;
    logic abort;
    logic [7:0] rdata;
  } ofec_top_st_t;

  function automatic logic [7:0] ofec_chunk_len(input logic [1:0] sel);
    return `OFEC_BASE_CHUNK << sel;
  endfunction : ofec_chunk_len

  function automatic logic [7:0] ofec_parity(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ a[31:24];
  endfunction : ofec_parity
endpackage : ofec_pkg

// File: hw/ofec_check_acc.sv
// per-chunk check-code accumulator: XOR of each data line over a chunk
// assumes beats are one-cycle strobes on CLK domain
`timescale 1ns/1ps
`default_nettype none
module ofec_check_acc (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic start_in,
  input wire logic beat_in,
  input wire logic [7:0] byte_in,
  input wire logic [7:0] len_in,
  output logic [7:0] code_out,
  output logic at_code_out
);
  ofec_pkg::ofec_acc_st_t q, n;

  assign code_out = q.code;
  // the beat after a full chunk carries the code byte
  assign at_code_out = (q.cnt == len_in);

  always_comb begin
    n = q;
    if (start_in) begin
      n.code = 8'h00;
      n.cnt = 8'h00;
    end else if (beat_in) begin
      if (at_code_out) begin
        n.code = 8'h00;
        n.cnt = 8'h00;
      end else begin
        n.code = q.code ^ byte_in;
        n.cnt = q.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  chk_acc_wrap : assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    beat_in && !start_in && at_code_out |=> q.cnt == 8'h00)
    else $error("count did not restart after code byte");
endmodule : ofec_check_acc
`default_nettype wire

// File: hw/ofec_inband_rst.sv
// in-band reset detector: four select pulses with no clock, line 0 pattern
// assumes synchronised, edge-detected select and clock from the top
`timescale 1ns/1ps
`default_nettype none
`include "ofec_map.svh"
module ofec_inband_rst #(
  parameter logic [7:0] HOLD_CYCLES = 8'(`OFEC_IBR_CYC)
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic cs_rise_in,
  input wire logic cs_low_in,
  input wire logic sclk_edge_in,
  input wire logic dq0_in,
  output logic fire_out,
  output logic busy_out
);
  ofec_pkg::ofec_ibr_st_t q, n;
  logic [3:0] pat_next;

  assign fire_out = q.fire;
  assign busy_out = q.busy;
  assign pat_next = {q.pat[2:0], dq0_in};

  always_comb begin
    n = q;
    n.fire = 1'b0;
    if (q.hold != 8'h00) begin
      n.hold = q.hold - 8'h01;
    end else if (sclk_edge_in && cs_low_in) begin
      // a clocked frame is a command; its closing select edge must not count
      n.cnt = 3'h7;
    end else if (cs_rise_in) begin
      n.pat = pat_next;
      if (q.cnt == 3'h7) begin
        n.cnt = 3'h0;
      end else if (q.cnt == 3'h3) begin
        n.cnt = 3'h0;
        if (pat_next == `OFEC_IBR_PAT) begin
          n.fire = 1'b1;
          n.hold = HOLD_CYCLES;
        end
      end else begin
        n.cnt = q.cnt + 3'h1;
      end
    end
    n.busy = (n.hold != 8'h00);
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  sequence s_fourth_good;
    cs_rise_in && q.cnt == 3'h3 && pat_next == `OFEC_IBR_PAT && !q.busy;
  endsequence

  chk_ibr_fire : assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    s_fourth_good |=> fire_out ##1 busy_out)
    else $error("in-band reset pattern did not fire");
  chk_ibr_ignore : assert property (
    @(posedge clk_in) disable iff (!nrst_in)
    busy_out |=> !fire_out)
    else $error("select activity acted on during reset");
endmodule : ofec_inband_rst
`default_nettype wire

// File: hw/ofec_top.sv
// error-check and error-report logic of an octal serial flash
// assumes a command decoder on CLK_IN giving starts, clears and reg
// accesses; link pins arrive asynchronously and are synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "ofec_map.svh"
module ofec_top (
  input wire logic CLK_IN,
  input wire logic NRST_IN,
  input wire logic RESET_N_IN,
  input wire logic SCLK_IN,
  input wire logic CS_N_IN,
  input wire logic [7:0] DQ_IN,
  output logic [7:0] DQ_OUT,
  output logic DQ_OE_OUT,
  output logic ERR_OUT,
  output logic ERR_OE_OUT,
  input wire logic START_IN,
  input wire logic OP_READ_IN,
  input wire logic [31:0] OP_ADDR_IN,
  input wire logic [7:0] OP_PAR_IN,
  input wire logic [7:0] RD_BYTE_IN,
  output logic RD_TAKE_OUT,
  output logic ABORT_OUT,
  output logic PROG_FAIL_OUT,
  input wire logic ECC_EVT_IN,
  input wire logic ECC_DBL_IN,
  input wire logic [31:0] ECC_ADDR_IN,
  input wire logic PROG_ECC_ABORT_IN,
  input wire logic CLR_ERR_IN,
  input wire logic CLR_FLAG_IN,
  input wire logic SW_RST_IN,
  input wire logic REG_WE_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [7:0] REG_WDATA_IN,
  output logic [7:0] REG_RDATA_OUT,
  output logic INBAND_RST_OUT
);
  // sampler starts at the pins' idle levels, so reset makes no false edge
  localparam ofec_pkg::ofec_top_st_t RST_ST = '{
    sy1: 11'h402, sy2: 11'h402, sy3: 2'h2,
    cfg: `OFEC_CFG_RST, mode: ofec_pkg::OFEC_IDLE, default: '0};

  ofec_pkg::ofec_top_st_t q, n;

  logic sclk_edge, cs_low, cs_rise, hw_rst, clear_all, beat;
  logic ibr_fire, ibr_busy;
  logic acc_start, acc_beat, at_code, code_bad, ev_sel;
  logic [7:0] acc_byte, acc_code, chunk_len, dq_s, stat;

  // ------------------------------------------------------------
  // pin sampling
  // ------------------------------------------------------------
  // sy1 is read only by sy2; all decisions look at sy2 and sy3
  assign sclk_edge = q.sy2[0] ^ q.sy3[0];
  assign cs_low = !q.sy2[1];
  assign cs_rise = q.sy2[1] && !q.sy3[1];
  assign dq_s = q.sy2[9:2];
  assign hw_rst = !q.sy2[10];
  assign beat = sclk_edge && cs_low && !ibr_busy;
  assign clear_all = hw_rst || SW_RST_IN || ibr_fire;

  // ------------------------------------------------------------
  // check-code path
  // ------------------------------------------------------------
  assign chunk_len = ofec_pkg::ofec_chunk_len(q.cfg[`OFEC_CFG_CSZ]);
  assign acc_start = START_IN;
  assign acc_beat = beat && q.chk &&
    (q.mode == ofec_pkg::OFEC_PROG || q.mode == ofec_pkg::OFEC_READ);
  assign acc_byte = (q.mode == ofec_pkg::OFEC_READ) ? RD_BYTE_IN : dq_s;
  assign code_bad = acc_beat && q.mode == ofec_pkg::OFEC_PROG &&
    at_code && dq_s != acc_code;
  assign ev_sel = ECC_EVT_IN &&
    (q.cfg[`OFEC_CFG_EVSEL] ? ECC_DBL_IN : !ECC_DBL_IN);
  assign stat = {q.pab, q.ecc_cnt, q.ecc_dbl, q.par_err, q.crc_err};

  ofec_check_acc u_acc (
    .clk_in(CLK_IN),
    .nrst_in(NRST_IN),
    .start_in(acc_start),
    .beat_in(acc_beat),
    .byte_in(acc_byte),
    .len_in(chunk_len),
    .code_out(acc_code),
    .at_code_out(at_code)
  );

  ofec_inband_rst u_ibr (
    .clk_in(CLK_IN),
    .nrst_in(NRST_IN),
    .cs_rise_in(cs_rise),
    .cs_low_in(cs_low),
    .sclk_edge_in(sclk_edge),
    .dq0_in(dq_s[0]),
    .fire_out(ibr_fire),
    .busy_out(ibr_busy)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    n = q;
    n.sy1 = {RESET_N_IN, DQ_IN, CS_N_IN, SCLK_IN};
    n.sy2 = q.sy1;
    n.sy3 = q.sy2[1:0];
    n.take = 1'b0;
    n.abort = 1'b0;
    n.err_o = 1'b0;

    if (REG_WE_IN && REG_ADDR_IN == `OFEC_CFG_ADDR) begin
      n.cfg = REG_WDATA_IN;
    end
    case (REG_ADDR_IN)
      `OFEC_CFG_ADDR: n.rdata = q.cfg;
      `OFEC_STAT_ADDR: n.rdata = stat;
      `OFEC_FA0_ADDR: n.rdata = q.faddr[7:0];
      `OFEC_FA1_ADDR: n.rdata = q.faddr[15:8];
      `OFEC_FA2_ADDR: n.rdata = q.faddr[23:16];
      `OFEC_FA3_ADDR: n.rdata = q.faddr[31:24];
      default: n.rdata = 8'h00;
    endcase

    // clears come first so that a same-cycle event still sets its flag
    if (CLR_ERR_IN) begin
      n.err_oe = 1'b0;
      n.crc_err = 1'b0;
      n.par_err = 1'b0;
      n.ecc_dbl = 1'b0;
      n.ecc_cnt = 4'h0;
      n.pab = 1'b0;
      n.faddr = 32'h0;
      n.faddr_vld = 1'b0;
    end
    if (CLR_FLAG_IN) begin
      n.prog_fail = 1'b0;
    end

    if (START_IN) begin
      n.seen_clk = 1'b0;
      n.chk = OP_READ_IN ? q.cfg[`OFEC_CFG_RCHK] : q.cfg[`OFEC_CFG_PCHK];
      if (n.chk && OP_PAR_IN != ofec_pkg::ofec_parity(OP_ADDR_IN)) begin
        n.par_err = 1'b1;
        n.mode = ofec_pkg::OFEC_HALT;
        n.abort = !OP_READ_IN;
        n.prog_fail = n.prog_fail || !OP_READ_IN;
      end else if (n.chk && (OP_ADDR_IN[7:0] & (chunk_len - 8'h01)) != 8'h00)
      begin
        n.crc_err = 1'b1;
        n.mode = ofec_pkg::OFEC_HALT;
        n.abort = 1'b1;
        n.prog_fail = n.prog_fail || !OP_READ_IN;
      end else if (OP_READ_IN) begin
        n.mode = ofec_pkg::OFEC_READ;
      end else begin
        n.mode = n.chk ? ofec_pkg::OFEC_PROG : ofec_pkg::OFEC_IDLE;
      end
    end else if (beat) begin
      n.seen_clk = 1'b1;
      case (q.mode)
        ofec_pkg::OFEC_PROG: begin
          if (code_bad) begin
            n.crc_err = 1'b1;
            n.prog_fail = 1'b1;
            n.abort = 1'b1;
            n.mode = ofec_pkg::OFEC_HALT;
          end
        end
        ofec_pkg::OFEC_READ: begin
          // outputs start only after a clock edge inside the frame
          n.dq_oe = 1'b1;
          if (q.chk && at_code) begin
            n.dq_o = acc_code;
          end else begin
            n.dq_o = RD_BYTE_IN;
            n.take = 1'b1;
          end
        end
        default: n.dq_oe = 1'b0;
      endcase
    end
    if (cs_rise || !cs_low) begin
      n.dq_oe = 1'b0;
    end
    if (cs_rise) begin
      n.mode = ofec_pkg::OFEC_IDLE;
    end

    if (ECC_EVT_IN) begin
      if (n.ecc_cnt != 4'hf) begin
        n.ecc_cnt = n.ecc_cnt + 4'h1;
      end
      if (ECC_DBL_IN) begin
        n.ecc_dbl = 1'b1;
      end
    end
    if (ev_sel) begin
      n.err_oe = 1'b1;
      if (!n.faddr_vld) begin
        n.faddr = ECC_ADDR_IN;
        n.faddr_vld = 1'b1;
      end
    end
    if (PROG_ECC_ABORT_IN) begin
      n.pab = 1'b1;
    end

    if (clear_all) begin
      n = RST_ST;
      n.sy1 = {RESET_N_IN, DQ_IN, CS_N_IN, SCLK_IN};
      n.sy2 = q.sy1;
      n.sy3 = q.sy2[1:0];
    end
  end

  always_ff @(posedge CLK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      q <= RST_ST;
    end else begin
      q <= n;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign DQ_OUT = q.dq_o;
  assign DQ_OE_OUT = q.dq_oe;
  assign ERR_OUT = q.err_o;
  assign ERR_OE_OUT = q.err_oe;
  assign RD_TAKE_OUT = q.take;
  assign ABORT_OUT = q.abort;
  assign PROG_FAIL_OUT = q.prog_fail;
  assign REG_RDATA_OUT = q.rdata;
  assign INBAND_RST_OUT = ibr_busy;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);

  sequence s_sel_event;
    ev_sel && !clear_all;
  endsequence
  sequence s_clean_clear;
    CLR_ERR_IN && !ECC_EVT_IN && !START_IN && !beat && !clear_all;
  endsequence

  chk_err_latency : assert property (
    s_sel_event |-> ##[1:2] ERR_OE_OUT)
    else $error("error pin late after ECC event");
  chk_err_sticky : assert property (
    ERR_OE_OUT && !CLR_ERR_IN && !clear_all |=> ERR_OE_OUT)
    else $error("error pin released without clear");
  chk_err_type : assert property (
    ECC_EVT_IN && !ECC_DBL_IN && q.cfg[`OFEC_CFG_EVSEL] && !ERR_OE_OUT
    |=> !ERR_OE_OUT)
    else $error("single event drove pin in double mode");
  chk_clr_release : assert property (s_clean_clear |=>
    !ERR_OE_OUT && stat == 8'h00 && !q.faddr_vld)
    else $error("clear-error left state behind");
  chk_crc_abort : assert property (code_bad && !clear_all |=>
    ABORT_OUT && stat[0] && PROG_FAIL_OUT)
    else $error("bad check code not aborted");
  chk_read_code : assert property (
    acc_beat && q.mode == ofec_pkg::OFEC_READ && at_code && !clear_all
    |=> DQ_OUT == $past(acc_code) && !RD_TAKE_OUT)
    else $error("read check code not output");
  chk_no_early_drive : assert property (DQ_OE_OUT |-> q.seen_clk)
    else $error("data driven before first clock edge");
  chk_reset_chunk : assert property (clear_all |=>
    q.cfg[5:4] == 2'b00 && !ERR_OE_OUT && stat == 8'h00)
    else $error("reset left chunk size or errors");
  chk_pfail_clear : assert property (
    CLR_FLAG_IN && !START_IN && !beat && !clear_all |=> !PROG_FAIL_OUT)
    else $error("program-failure flag not cleared");
endmodule : ofec_top
`default_nettype wire

// File: tb/ofec_host_model.sv
// host controller model: drives link clock, select and data lines
// assumes the device's data outputs and output enable are fed back
`timescale 1ns/1ps
`default_nettype none
module ofec_host_model (
  output logic sclk_out,
  output logic cs_n_out,
  output logic [7:0] dq_out,
  input wire logic [7:0] dev_dq_in,
  input wire logic dev_oe_in
);
  logic [7:0] host_dq = 8'h00;
  logic host_oe = 1'b0;
  logic [7:0] last = 8'h00;
  logic rd_mode = 1'b0;
  logic first = 1'b1;
  logic [7:0] cap_byte;
  event cap_ev;
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
  end
  // a released line shows the inverse of its last level, never a hold
  assign dq_out = dev_oe_in ? dev_dq_in : (host_oe ? host_dq : ~last);
  always @(dq_out) if (dev_oe_in || host_oe) last = dq_out;
  task capture;
    cap_byte = dq_out;
    // only driven bytes are compared; a missing byte stays in the queue
    if (rd_mode && dev_oe_in) ->cap_ev;
  endtask : capture
  // clock stands still between frames; every toggle is one beat
  task frame_open(input logic rd);
    rd_mode = rd;
    host_oe = !rd;
    first = 1'b1;
    cs_n_out = 1'b0;
    #200;
  endtask : frame_open
  // one toggle; the byte of the previous beat is captured first
  task beat(input logic [7:0] b);
    host_dq = b;
    #31.25;
    if (!first) capture();
    first = 1'b0;
    sclk_out = ~sclk_out;
    #31.25;
  endtask : beat
  task frame_close;
    #31.25;
    capture();
    #31.25;
    host_oe = 1'b0;
    cs_n_out = 1'b1;
    rd_mode = 1'b0;
    #500;
  endtask : frame_close
  // select pulse with data line 0 set at the falling edge, clock still
  task ibr_pulse(input logic b);
    host_oe = 1'b1;
    host_dq = {7'h00, b};
    cs_n_out = 1'b0;
    #500;
    cs_n_out = 1'b1;
    // line 0 held past two system clocks so the sampler sees it with select
    #25;
    host_oe = 1'b0;
    #480;
  endtask : ibr_pulse
endmodule : ofec_host_model
`default_nettype wire

// File: tb/test_octal_flash_error_check.sv
// bench of the error-check block: link traffic via the host model,
// command decoder, core and register port driven here on falling edges
`timescale 1ns/1ps
`default_nettype none
module test_octal_flash_error_check;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hw_rst_n = 1'b1;
  logic start = 1'b0;
  logic op_rd = 1'b0;
  logic [31:0] op_addr = 32'h0;
  logic [7:0] op_par = 8'h00;
  logic [7:0] rd_byte = 8'h00;
  logic [4:0] ctl = 5'h00; // clr_err clr_flag sw_rst ecc_evt prog_ecc
  logic ecc_dbl = 1'b0;
  logic [31:0] ecc_addr = 32'h0;
  logic reg_we = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic sclk, cs_n, dq_oe, err_o, err_oe, rd_take, abort, pfail, ibr;
  logic [7:0] dq, dq_o, rdata, rd_acc;
  logic [31:0] seed = 32'h11c064fc;
  logic [31:0] fa;
  int err_count = 0;
  int compares = 0;
  int abort_cnt = 0;
  int cyc = 0;
  int rd_n = 0;
  logic oe_seen = 1'b0;
  logic ibr_seen = 1'b0;
  logic [7:0] exp_q[$];
  wire logic err_line = err_oe ? err_o : 1'b1;
  always #5 clk = ~clk;
  ofec_host_model host_i (.sclk_out(sclk), .cs_n_out(cs_n), .dq_out(dq),
    .dev_dq_in(dq_o), .dev_oe_in(dq_oe));
  ofec_top ofec_top_i (.CLK_IN(clk), .NRST_IN(nrst), .RESET_N_IN(hw_rst_n),
    .SCLK_IN(sclk), .CS_N_IN(cs_n), .DQ_IN(dq), .DQ_OUT(dq_o),
    .DQ_OE_OUT(dq_oe), .ERR_OUT(err_o), .ERR_OE_OUT(err_oe),
    .START_IN(start), .OP_READ_IN(op_rd), .OP_ADDR_IN(op_addr),
    .OP_PAR_IN(op_par), .RD_BYTE_IN(rd_byte), .RD_TAKE_OUT(rd_take),
    .ABORT_OUT(abort), .PROG_FAIL_OUT(pfail), .ECC_EVT_IN(ctl[3]),
    .ECC_DBL_IN(ecc_dbl), .ECC_ADDR_IN(ecc_addr),
    .PROG_ECC_ABORT_IN(ctl[4]), .CLR_ERR_IN(ctl[0]), .CLR_FLAG_IN(ctl[1]),
    .SW_RST_IN(ctl[2]), .REG_WE_IN(reg_we), .REG_ADDR_IN(reg_addr),
    .REG_WDATA_IN(reg_wdata), .REG_RDATA_OUT(rdata), .INBAND_RST_OUT(ibr));
  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test;
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  task automatic rnd(output logic [7:0] r);
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    r = seed[7:0];
  endtask : rnd
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_we = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_we = 1'b0;
  endtask : reg_wr
  task automatic reg_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_addr = a;
    @(negedge clk);
    check($sformatf("reg %h", a), 32'(rdata), 32'(e));
  endtask : reg_chk
  task automatic pulse(input int i);
    @(negedge clk);
    ctl[i] = 1'b1;
    @(negedge clk);
    ctl[i] = 1'b0;
  endtask : pulse
  // parity byte is the XOR of the four address bytes, spoilt on demand
  task automatic op(input logic rd, input logic [31:0] a, input logic ok);
    @(negedge clk);
    start = 1'b1;
    op_rd = rd;
    op_addr = a;
    op_par = a[7:0] ^ a[15:8] ^ a[23:16] ^ a[31:24] ^ {7'h00, !ok};
    @(negedge clk);
    start = 1'b0;
  endtask : op
  task automatic prog(input logic [31:0] a, input int clen, input int n,
                      input int bad, input logic ok);
    logic [7:0] b;
    logic [7:0] code;
    host_i.frame_open(1'b0);
    op(1'b0, a, ok);
    for (int c = 0; c < n; c++) begin
      code = 8'h00;
      for (int i = 0; i < clen; i++) begin
        rnd(b);
        code = code ^ b;
        host_i.beat(b);
      end
      host_i.beat(c == bad ? ~code : code);
    end
    host_i.frame_close();
  endtask : prog
  task automatic rd(input logic [31:0] a, input int beats);
    rd_n = 0;
    rd_acc = 8'h00;
    host_i.frame_open(1'b1);
    op(1'b1, a, 1'b1);
    repeat (beats) host_i.beat(8'h00);
    host_i.frame_close();
  endtask : rd
  task automatic ecc(input logic dbl, input logic [31:0] a);
    ecc_dbl = dbl;
    ecc_addr = a;
    pulse(3);
    @(negedge clk);
  endtask : ecc
  task automatic ibr_seq(input logic [3:0] p);
    for (int i = 0; i < 4; i++) host_i.ibr_pulse(p[i]);
    #400;
  endtask : ibr_seq
  // --------------------------------------------------------------
  // core model, monitors and timeout
  // --------------------------------------------------------------
  // each byte taken is noted; a chunk's code follows its last byte
  always @(negedge clk) begin
    if (rd_take === 1'b1) begin
      exp_q.push_back(rd_byte);
      rd_acc = rd_acc ^ rd_byte;
      rd_n++;
      if (rd_n == 16) begin
        exp_q.push_back(rd_acc);
        rd_acc = 8'h00;
        rd_n = 0;
      end
      rnd(rd_byte);
    end
  end
  always @(host_i.cap_ev) begin
    if (exp_q.size() == 0) check("read extra", 1, 0);
    else check("read byte", host_i.cap_byte, exp_q.pop_front());
  end
  always @(posedge clk) begin
    cyc++;
    if (abort === 1'b1) abort_cnt++;
    if (dq_oe === 1'b1) oe_seen = 1'b1;
    if (ibr === 1'b1) ibr_seen = 1'b1;
    if (cyc == 60000) begin
      err_count++;
      end_of_test();
    end
  end
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    reg_chk(8'h0b, 8'h40);
    reg_chk(8'h0c, 8'h00);
    reg_chk(8'h20, 8'h00);
    reg_wr(8'h0c, 8'hff);
    reg_chk(8'h0c, 8'h00);
    reg_wr(8'h0b, 8'hc8);
    reg_chk(8'h0b, 8'hc8);
    prog(32'h100, 16, 2, -1, 1'b1);
    check("abort good", abort_cnt, 0);
    prog(32'h120, 16, 2, 1, 1'b1);
    check("abort bad", abort_cnt, 1);
    check("prog fail", pfail, 1);
    reg_chk(8'h0c, 8'h01);
    prog(32'h140, 16, 1, -1, 1'b1);
    reg_chk(8'h0c, 8'h01);
    pulse(1);
    check("prog fail clr", pfail, 0);
    pulse(0);
    reg_chk(8'h0c, 8'h00);
    rd(32'h200, 34);
    check("read left", exp_q.size(), 0);
    oe_seen = 1'b0;
    rd(32'h204, 17);
    check("misaligned drive", oe_seen, 0);
    check("abort misaligned", abort_cnt, 2);
    reg_chk(8'h0c, 8'h01);
    prog(32'h300, 16, 1, -1, 1'b0);
    reg_chk(8'h0c, 8'h03);
    check("parity fail", pfail, 1);
    pulse(0);
    pulse(1);
    reg_chk(8'h0c, 8'h00);
    reg_wr(8'h0b, 8'hd8);
    prog(32'h400, 32, 2, -1, 1'b1);
    check("abort 32", abort_cnt, 3);
    reg_chk(8'h0c, 8'h00);
    ecc(1'b0, 32'h10);
    check("err single", err_line, 0);
    pulse(0);
    check("err clr", err_line, 1);
    reg_wr(8'h0b, 8'hdc);
    ecc(1'b0, 32'h20);
    @(negedge clk);
    check("err sel", err_line, 1);
    reg_chk(8'h0c, 8'h08);
    fa = seed;
    ecc(1'b1, fa);
    check("err dbl", err_line, 0);
    ecc(1'b1, ~fa);
    pulse(4);
    reg_chk(8'h0c, 8'h9c);
    reg_chk(8'h0d, fa[7:0]);
    reg_chk(8'h0e, fa[15:8]);
    reg_chk(8'h0f, fa[23:16]);
    reg_chk(8'h10, fa[31:24]);
    pulse(2);
    repeat (2) @(negedge clk);
    check("err sw", err_line, 1);
    reg_chk(8'h0c, 8'h00);
    reg_chk(8'h0d, 8'h00);
    reg_chk(8'h0b, 8'h40);
    ecc(1'b0, 32'h30);
    hw_rst_n = 1'b0;
    repeat (6) @(negedge clk);
    hw_rst_n = 1'b1;
    repeat (6) @(negedge clk);
    check("err hw", err_line, 1);
    reg_chk(8'h0c, 8'h00);
    reg_wr(8'h0b, 8'hc8);
    ecc(1'b0, 32'h40);
    ibr_seq(4'h0);
    check("ibr bad", ibr_seen, 0);
    host_i.frame_open(1'b0);
    host_i.beat(8'h00);
    host_i.frame_close();
    oe_seen = 1'b0;
    ibr_seq(4'ha);
    check("ibr fire", ibr_seen, 1);
    check("ibr drive", oe_seen, 0);
    check("err ibr", err_line, 1);
    reg_chk(8'h0c, 8'h00);
    reg_chk(8'h0b, 8'h40);
    end_of_test();
  end
endmodule : test_octal_flash_error_check
`default_nettype wire
